// [design/gcso_cfg.svh]
// Register map, field layout, reset values and pin function codes for the GPIO status outputs
// Functional notes
// - Loop lock flags appear on a pin whose function select holds their code.
// - Rising and falling loop lock edges both latch an interrupt bit.
// - Interrupt bits stay latched, are readable any time, and drive the request output.
// - A latched interrupt bit clears only when software writes one to it.
// - Pin with synchronous clock-output code carries the synchronous divided clock.
// - Pin with asynchronous clock-output code carries the asynchronous divided clock.
// - Synchronous clock-output enable is bit 15, reset zero, output disabled.
// - Bits 7:3 give an even divide ratio from 2 to 30, reset zero.
// - Bits 2:0 select 6.144, 12.288, 24.576 or 49.152 MHz source; others reserved.
// - Asynchronous clock-output register has the same layout and zero reset.
// - Two PWM outputs are each selectable on a pin by own code.
// - The S/PDIF transmitter output is selectable on a pin by its code.
// - Rate-converter lock flags go to pins and latch interrupts on both edges.
// - Timer status pin pulses at final count; same event latches an interrupt.
// - Event-logger pin is high while its FIFO is not empty; raises interrupt.
// - Four alarm pins assert for a configurable time on trigger; latch interrupts.
// - Master-mode aux PDM clock goes on GPIO3 or GPIO10, data on GPIO4 or GPIO9.
// - Slave-mode aux PDM clock comes in on GPIO10; data leaves on GPIO9 only.
// - Bits 1:0: switch one open, closed, closed on clamp set, closed on clamp clear.
// - Bits 3:2 control switch two with the same encodings, reset zero.
`ifndef GCSO_CFG_SVH
`define GCSO_CFG_SVH

// Register indexes; byte address is four times the index
`define GCSO_IDX_SYNC_CLK   10'h149
`define GCSO_IDX_ASYNC_CLK  10'h14A
`define GCSO_IDX_SWITCH     10'h2C8
`define GCSO_IDX_IRQ_STAT   10'h300
`define GCSO_IDX_AUX_CTRL   10'h301
`define GCSO_IDX_RAW_STAT   10'h302
`define GCSO_PIN_FN_HI      6'h31

// Output-clock control fields
`define GCSO_CLK_ENA        15
`define GCSO_CLK_DIV_HI     7
`define GCSO_CLK_DIV_LO     3
`define GCSO_CLK_SEL_HI     2
`define GCSO_CLK_SEL_LO     0
`define GCSO_CLK_CTRL_MASK  16'h80FF
`define GCSO_CLK_CTRL_RST   16'h0000

// Switch control fields
`define GCSO_SW1_HI         1
`define GCSO_SW1_LO         0
`define GCSO_SW2_HI         3
`define GCSO_SW2_LO         2
`define GCSO_SWITCH_RST     4'h0

// Aux control fields and reset values
`define GCSO_AUX_MASTER     8
`define GCSO_ALARM_LEN_RST  8'h04
`define GCSO_PIN_FN_RST     10'h000

// Interrupt status bit positions
`define GCSO_IRQ_FLL_LSB    0
`define GCSO_IRQ_ASRC_LSB   2
`define GCSO_IRQ_TIMER      4
`define GCSO_IRQ_EVLOG      5
`define GCSO_IRQ_ALARM_LSB  6
`define GCSO_IRQ_RST        10'h000

// Pin function codes
`define GCSO_FN_FLL1_LOCK   10'h018
`define GCSO_FN_FLL2_LOCK   10'h019
`define GCSO_FN_SYNC_CLK    10'h040
`define GCSO_FN_ASYNC_CLK   10'h041
`define GCSO_FN_PWM1        10'h048
`define GCSO_FN_PWM2        10'h049
`define GCSO_FN_SPDIF       10'h04C
`define GCSO_FN_ASRC1_LOCK  10'h088
`define GCSO_FN_ASRC2_LOCK  10'h089
`define GCSO_FN_TIMER       10'h140
`define GCSO_FN_EVLOG       10'h150
`define GCSO_FN_ALARM1      10'h230
`define GCSO_FN_ALARM2      10'h231
`define GCSO_FN_ALARM3      10'h232
`define GCSO_FN_ALARM4      10'h233
`define GCSO_FN_AUX_CLK     10'h280
`define GCSO_FN_AUX_DAT     10'h281

// Pin indexes (GPIOn sits at index n-1)
`define GCSO_PIN_GPIO3      2
`define GCSO_PIN_GPIO4      3
`define GCSO_PIN_GPIO9      8
`define GCSO_PIN_GPIO10     9

`endif

// [design/gcso_clkdiv.sv]
// Even divider that turns a selected source-rate strobe into a divided clock
`timescale 1ns/1ps
`include "gcso_cfg.svh"
module gcso_clkdiv (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_enable,
  input  wire logic [4:0] i_divider,
  input  wire logic [2:0] i_source_select,
  input  wire logic [3:0] i_rate_tick,
  output logic            o_clk_out
);

  logic       tick;
  logic [3:0] half_m1;
  logic [3:0] cnt;

  // Reserved source codes give no strobe; half period is divider/2 strobes, or one strobe for a divider below 2
  always_comb begin
    tick    = (i_source_select[2] == 1'b0) ? i_rate_tick[i_source_select[1:0]] : 1'b0;
    half_m1 = (i_divider[4:1] == 4'h0) ? 4'h0 : (i_divider[4:1] - 4'h1);
  end

  // Disabled holds low with count cleared, so enable always starts a fresh low half
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt       <= 4'h0;
      o_clk_out <= 1'b0;
    end else if (!i_enable) begin
      cnt       <= 4'h0;
      o_clk_out <= 1'b0;
    end else if (tick) begin
      // Greater-or-equal recovers if the divider is cut while running
      if (cnt >= half_m1) begin
        cnt       <= 4'h0;
        o_clk_out <= ~o_clk_out;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_disabled_low: assert property (!i_enable |=> (!o_clk_out && cnt == 4'h0))
    else $error("divided clock not held low while disabled");
  a_toggle_point: assert property ((i_enable && tick && cnt >= half_m1) |=> o_clk_out != $past(o_clk_out))
    else $error("divided clock missed its toggle");
  a_no_tick_hold: assert property ((i_enable && !tick) |=> $stable(o_clk_out))
    else $error("divided clock moved without a source strobe");

endmodule

// [design/gcso_pkg.sv]
// Types shared by the GPIO status output block
package gcso_pkg;

  // Analog switch modes
  typedef enum logic [1:0] {
    GCSO_SW_OPEN      = 2'h0,
    GCSO_SW_CLOSED    = 2'h1,
    GCSO_SW_CLAMP_SET = 2'h2,
    GCSO_SW_CLAMP_CLR = 2'h3
  } gcso_sw_mode_t;

endpackage

// [design/gcso_top.sv]
// GPIO status outputs, divided clock outputs and analog switch control with an AHB-Lite register slave
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "gcso_cfg.svh"
module gcso_top
  import gcso_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic [1:0]  i_fll_lock,
  input  wire logic [1:0]  i_asrc_lock,
  input  wire logic        i_timer_final,
  input  wire logic        i_evlog_not_empty,
  input  wire logic [3:0]  i_alarm_trigger,
  input  wire logic [1:0]  i_pwm_out,
  input  wire logic        i_spdif_out,
  input  wire logic        i_aux_pdm_clk,
  input  wire logic        i_aux_pdm_data,
  input  wire logic        i_mic_detect_clamp,
  input  wire logic [3:0]  i_sync_rate_tick,
  input  wire logic [3:0]  i_async_rate_tick,
  input  wire logic        i_gpio10_in,
  output logic [15:0]      o_gpio_out,
  output logic [15:0]      o_gpio_oe,
  output logic             o_irq,
  output logic             o_switch_one_closed,
  output logic             o_switch_two_closed,
  output logic             o_aux_pdm_ext_clk,
  output logic             o_sync_divided_clock_out,
  output logic             o_async_divided_clock_out
);

  // Synchronisers and edge history
  logic [1:0]  fll_meta;
  logic [1:0]  fll_sync;
  logic [1:0]  fll_prev;
  logic [1:0]  asrc_meta;
  logic [1:0]  asrc_sync;
  logic [1:0]  asrc_prev;
  logic        gpio10_meta;
  logic        gpio10_sync;
  logic        evlog_prev;

  // Software-visible state
  logic [15:0] sync_ctrl;
  logic [15:0] async_ctrl;
  logic [3:0]  switch_ctrl;
  logic [9:0]  irq_status;
  logic        aux_master;
  logic [7:0]  alarm_len;
  logic [9:0]  pin_fn [16];

  // Internal datapath
  logic [7:0]  alarm_cnt [4];
  logic [3:0]  alarm_active;
  logic        wr_pend;
  logic [9:0]  wr_idx;
  logic        addr_ok;
  logic [9:0]  next_irq_set;
  logic [9:0]  irq_clear;
  logic [15:0] next_gpio_out;
  logic [15:0] next_gpio_oe;
  logic        sync_div_clk;
  logic        async_div_clk;

  // Switch closure for one mode field
  function automatic logic sw_closed(input logic [1:0] mode, input logic clamp);
    logic c;
    c = 1'b0;
    case (gcso_sw_mode_t'(mode))
      GCSO_SW_OPEN:      c = 1'b0;
      GCSO_SW_CLOSED:    c = 1'b1;
      GCSO_SW_CLAMP_SET: c = clamp;
      GCSO_SW_CLAMP_CLR: c = !clamp;
      default:           c = 1'b0;
    endcase
    return c;
  endfunction

  // Pin function register window
  function automatic logic is_pin_fn(input logic [9:0] idx);
    return idx[9:4] == `GCSO_PIN_FN_HI;
  endfunction

  // Drive pair {enable, level} for one pin and its function code
  function automatic logic [1:0] pin_drive(input logic [9:0] code, input int unsigned pin);
    logic [1:0] d;
    d = 2'b00;
    case (code)
      `GCSO_FN_FLL1_LOCK:  d = {1'b1, fll_sync[0]};
      `GCSO_FN_FLL2_LOCK:  d = {1'b1, fll_sync[1]};
      `GCSO_FN_SYNC_CLK:   d = {1'b1, sync_div_clk};
      `GCSO_FN_ASYNC_CLK:  d = {1'b1, async_div_clk};
      `GCSO_FN_PWM1:       d = {1'b1, i_pwm_out[0]};
      `GCSO_FN_PWM2:       d = {1'b1, i_pwm_out[1]};
      `GCSO_FN_SPDIF:      d = {1'b1, i_spdif_out};
      `GCSO_FN_ASRC1_LOCK: d = {1'b1, asrc_sync[0]};
      `GCSO_FN_ASRC2_LOCK: d = {1'b1, asrc_sync[1]};
      `GCSO_FN_TIMER:      d = {1'b1, i_timer_final};
      `GCSO_FN_EVLOG:      d = {1'b1, i_evlog_not_empty};
      `GCSO_FN_ALARM1:     d = {1'b1, alarm_active[0]};
      `GCSO_FN_ALARM2:     d = {1'b1, alarm_active[1]};
      `GCSO_FN_ALARM3:     d = {1'b1, alarm_active[2]};
      `GCSO_FN_ALARM4:     d = {1'b1, alarm_active[3]};
      `GCSO_FN_AUX_CLK: begin
        // Slave mode turns GPIO10 into an input, so nothing drives
        if (aux_master && (pin == `GCSO_PIN_GPIO3 || pin == `GCSO_PIN_GPIO10)) begin
          d = {1'b1, i_aux_pdm_clk};
        end
      end
      `GCSO_FN_AUX_DAT: begin
        if ((aux_master && pin == `GCSO_PIN_GPIO4) || pin == `GCSO_PIN_GPIO9) begin
          d = {1'b1, i_aux_pdm_data};
        end
      end
      default:             d = 2'b00;
    endcase
    return d;
  endfunction

  // Register read mux; reserved bits read as zero
  function automatic logic [31:0] read_word(input logic [9:0] idx);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (idx)
      `GCSO_IDX_SYNC_CLK:  r = {16'h0000, sync_ctrl};
      `GCSO_IDX_ASYNC_CLK: r = {16'h0000, async_ctrl};
      `GCSO_IDX_SWITCH:    r = {28'h000_0000, switch_ctrl};
      `GCSO_IDX_IRQ_STAT:  r = {22'h00_0000, irq_status};
      `GCSO_IDX_AUX_CTRL:  r = {23'h00_0000, aux_master, alarm_len};
      `GCSO_IDX_RAW_STAT:  r = {28'h000_0000, asrc_sync, fll_sync};
      default: begin
        if (is_pin_fn(idx)) begin
          r = {22'h00_0000, pin_fn[idx[3:0]]};
        end
      end
    endcase
    return r;
  endfunction

  // Lock flags and the pin input come from other clocks: two flops first
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fll_meta    <= 2'h0;
      fll_sync    <= 2'h0;
      asrc_meta   <= 2'h0;
      asrc_sync   <= 2'h0;
      gpio10_meta <= 1'b0;
      gpio10_sync <= 1'b0;
    end else begin
      fll_meta    <= i_fll_lock;
      fll_sync    <= fll_meta;
      asrc_meta   <= i_asrc_lock;
      asrc_sync   <= asrc_meta;
      gpio10_meta <= i_gpio10_in;
      gpio10_sync <= gpio10_meta;
    end
  end

  // Lock edge history taken from the second synchroniser stage; logger history from the raw input
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fll_prev   <= 2'h0;
      asrc_prev  <= 2'h0;
      evlog_prev <= 1'b0;
    end else begin
      fll_prev   <= fll_sync;
      asrc_prev  <= asrc_sync;
      evlog_prev <= i_evlog_not_empty;
    end
  end

  // Bus address phase: single words only, so narrow sizes are not decoded
  assign addr_ok = i_hsel && i_hready && i_htrans[1] && (i_haddr[31:12] == 20'h0_0000);

  // Zero-wait slave; read data is fetched at the address edge
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_pend     <= 1'b0;
      wr_idx      <= 10'h000;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pend     <= addr_ok && i_hwrite;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (addr_ok) begin
        wr_idx <= i_haddr[11:2];
      end
      o_hrdata <= (addr_ok && !i_hwrite) ? read_word(i_haddr[11:2]) : 32'h0000_0000;
    end
  end

  // Configuration registers written in the data phase
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_ctrl   <= `GCSO_CLK_CTRL_RST;
      async_ctrl  <= `GCSO_CLK_CTRL_RST;
      switch_ctrl <= `GCSO_SWITCH_RST;
      aux_master  <= 1'b0;
      alarm_len   <= `GCSO_ALARM_LEN_RST;
      for (int p = 0; p < 16; p++) begin
        pin_fn[p] <= `GCSO_PIN_FN_RST;
      end
    end else if (wr_pend) begin
      case (wr_idx)
        `GCSO_IDX_SYNC_CLK:  sync_ctrl   <= i_hwdata[15:0] & `GCSO_CLK_CTRL_MASK;
        `GCSO_IDX_ASYNC_CLK: async_ctrl  <= i_hwdata[15:0] & `GCSO_CLK_CTRL_MASK;
        `GCSO_IDX_SWITCH:    switch_ctrl <= i_hwdata[3:0];
        `GCSO_IDX_AUX_CTRL: begin
          aux_master <= i_hwdata[`GCSO_AUX_MASTER];
          alarm_len  <= i_hwdata[7:0];
        end
        default: begin
          if (is_pin_fn(wr_idx)) begin
            pin_fn[wr_idx[3:0]] <= i_hwdata[9:0];
          end
        end
      endcase
    end
  end

  // Event sources: lock flags on both edges, logger on becoming non-empty
  always_comb begin
    next_irq_set = 10'h000;
    next_irq_set[`GCSO_IRQ_FLL_LSB +: 2]   = fll_sync ^ fll_prev;
    next_irq_set[`GCSO_IRQ_ASRC_LSB +: 2]  = asrc_sync ^ asrc_prev;
    next_irq_set[`GCSO_IRQ_TIMER]          = i_timer_final;
    next_irq_set[`GCSO_IRQ_EVLOG]          = i_evlog_not_empty && !evlog_prev;
    next_irq_set[`GCSO_IRQ_ALARM_LSB +: 4] = i_alarm_trigger;
    irq_clear = (wr_pend && wr_idx == `GCSO_IDX_IRQ_STAT) ? i_hwdata[9:0] : 10'h000;
  end

  // Sticky bits, write-one-to-clear; a same-cycle event beats the clear
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_status <= `GCSO_IRQ_RST;
      o_irq      <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | next_irq_set;
      o_irq      <= |irq_status;
    end
  end

  // Alarm stretchers; retrigger reloads the full length, zero length gives no pulse
  for (genvar a = 0; a < 4; a++) begin : g_alarm
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        alarm_cnt[a] <= 8'h00;
      end else if (i_alarm_trigger[a]) begin
        alarm_cnt[a] <= alarm_len;
      end else if (alarm_cnt[a] != 8'h00) begin
        alarm_cnt[a] <= alarm_cnt[a] - 8'h01;
      end
    end
    assign alarm_active[a] = (alarm_cnt[a] != 8'h00);
  end

  // Divided clock from the synchronous system clock rates
  gcso_clkdiv u_sync_div (
    .i_core_clk      (i_core_clk),
    .i_sys_rst       (i_sys_rst),
    .i_enable        (sync_ctrl[`GCSO_CLK_ENA]),
    .i_divider       (sync_ctrl[`GCSO_CLK_DIV_HI:`GCSO_CLK_DIV_LO]),
    .i_source_select (sync_ctrl[`GCSO_CLK_SEL_HI:`GCSO_CLK_SEL_LO]),
    .i_rate_tick     (i_sync_rate_tick),
    .o_clk_out       (sync_div_clk)
  );

  // Divided clock from the asynchronous domain rates
  gcso_clkdiv u_async_div (
    .i_core_clk      (i_core_clk),
    .i_sys_rst       (i_sys_rst),
    .i_enable        (async_ctrl[`GCSO_CLK_ENA]),
    .i_divider       (async_ctrl[`GCSO_CLK_DIV_HI:`GCSO_CLK_DIV_LO]),
    .i_source_select (async_ctrl[`GCSO_CLK_SEL_HI:`GCSO_CLK_SEL_LO]),
    .i_rate_tick     (i_async_rate_tick),
    .o_clk_out       (async_div_clk)
  );

  // Pin multiplexer
  always_comb begin
    logic [1:0] d;
    d             = 2'b00;
    next_gpio_out = 16'h0000;
    next_gpio_oe  = 16'h0000;
    for (int p = 0; p < 16; p++) begin
      d                = pin_drive(pin_fn[p], p);
      next_gpio_oe[p]  = d[1];
      next_gpio_out[p] = d[0];
    end
  end

  // Registered pin, switch and clock outputs; each adds one cycle of latency
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_gpio_out                <= 16'h0000;
      o_gpio_oe                 <= 16'h0000;
      o_switch_one_closed       <= 1'b0;
      o_switch_two_closed       <= 1'b0;
      o_aux_pdm_ext_clk         <= 1'b0;
      o_sync_divided_clock_out  <= 1'b0;
      o_async_divided_clock_out <= 1'b0;
    end else begin
      o_gpio_out                <= next_gpio_out;
      o_gpio_oe                 <= next_gpio_oe;
      o_switch_one_closed       <= sw_closed(switch_ctrl[`GCSO_SW1_HI:`GCSO_SW1_LO], i_mic_detect_clamp);
      o_switch_two_closed       <= sw_closed(switch_ctrl[`GCSO_SW2_HI:`GCSO_SW2_LO], i_mic_detect_clamp);
      o_aux_pdm_ext_clk         <= !aux_master && (pin_fn[`GCSO_PIN_GPIO10] == `GCSO_FN_AUX_CLK)
                                   && gpio10_sync;
      o_sync_divided_clock_out  <= sync_div_clk;
      o_async_divided_clock_out <= async_div_clk;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_fll_edge_irq: assert property ($changed(fll_sync[0]) |=> irq_status[`GCSO_IRQ_FLL_LSB])
    else $error("lock edge did not latch interrupt");
  a_irq_sticky: assert property (
    (irq_status[0] && !(wr_pend && wr_idx == `GCSO_IDX_IRQ_STAT && i_hwdata[0])) |=> irq_status[0])
    else $error("interrupt bit dropped without write-one");
  a_set_beats_clear: assert property (
    (next_irq_set[`GCSO_IRQ_TIMER] && irq_clear[`GCSO_IRQ_TIMER]) |=> irq_status[`GCSO_IRQ_TIMER])
    else $error("clear won over a same-cycle event");
  a_irq_output: assert property (
    (irq_status != 10'h000) |=> o_irq ##1 (o_irq || $past(irq_status) == 10'h000))
    else $error("interrupt output not following status");
  a_fll_on_pin: assert property (
    (pin_fn[4] == `GCSO_FN_FLL2_LOCK) |=> (o_gpio_oe[4] && o_gpio_out[4] == $past(fll_sync[1])))
    else $error("lock flag missing on pin");
  a_sync_clk_pin: assert property (
    (pin_fn[0] == `GCSO_FN_SYNC_CLK) |=> (o_gpio_oe[0] && o_gpio_out[0] == $past(sync_div_clk)))
    else $error("synchronous divided clock missing on pin");
  a_alarm_length: assert property (
    (i_alarm_trigger[0] && alarm_len == 8'h03)
    ##1 (!i_alarm_trigger[0] && alarm_active[0]) [*3] |=> !alarm_active[0])
    else $error("alarm pulse length wrong");
  a_switch_clamp: assert property (
    (switch_ctrl[1:0] == 2'h3) |=> (o_switch_one_closed == !$past(i_mic_detect_clamp)))
    else $error("switch one not tracking clear clamp");
  a_aux_slave_pin: assert property (
    (!aux_master && pin_fn[`GCSO_PIN_GPIO3] == `GCSO_FN_AUX_CLK) |=> !o_gpio_oe[`GCSO_PIN_GPIO3])
    else $error("slave mode drove aux clock on GPIO3");

endmodule

// [dv/gcso_pin_partner.sv]
// External peripheral that supplies the aux PDM clock on GPIO10
`timescale 1ns/1ps
module gcso_pin_partner (
  input  wire logic i_core_clk,
  input  wire logic i_run,
  output logic      o_pin
);
  logic [1:0] ph;

  initial begin
    o_pin = 1'b0;
    ph    = 2'h0;
  end

  // Toggle every third cycle only while a frame runs; the line stands still between frames
  always @(posedge i_core_clk) begin
    if (i_run) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2) o_pin <= ~o_pin;
    end
  end
endmodule

// [dv/gcso_tb_top.sv]
// Self-checking bench for the GPIO status output block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module gcso_tb_top;
  import gcso_pkg::*;
  typedef struct {int id; logic [31:0] e; logic [31:0] g;} gcso_note_t;
  logic        i_core_clk = 1'b0, i_sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        tfin = 1'b0, clamp = 1'b0, prun = 1'b0, last = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, rdat = '0, meas = '0;
  logic [1:0]  htrans = '0;
  logic [9:0]  src = '0;
  logic [3:0]  alm = '0;
  logic [2:0]  tcnt = '0;
  logic [3:0]  tick;
  logic        hro, hresp, irq, sw1, sw2, pdmx, sclk, aclk, p10;
  logic [31:0] hrdata;
  logic [15:0] gout, goe;
  logic [9:0]  fn [8] = '{10'h018, 10'h019, 10'h088, 10'h089, 10'h048, 10'h049, 10'h04C, 10'h150};
  int          error_cnt = 0, check_count = 0, seed = 32'hefe1_0037, d;
  gcso_note_t  q[$], nt;
  event        probe;

  // Clock and source-rate strobes; bit n strobes every 2^n cycles
  always #12.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) tcnt <= tcnt + 3'h1;
  assign tick = {tcnt == 3'h0, tcnt[1:0] == 2'h0, ~tcnt[0], 1'b1};

  gcso_top uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hro),
    .o_hreadyout(hro), .o_hresp(hresp), .o_hrdata(hrdata), .i_fll_lock(src[1:0]),
    .i_asrc_lock(src[3:2]), .i_timer_final(tfin), .i_evlog_not_empty(src[7]), .i_alarm_trigger(alm),
    .i_pwm_out(src[5:4]), .i_spdif_out(src[6]), .i_aux_pdm_clk(src[8]), .i_aux_pdm_data(src[9]),
    .i_mic_detect_clamp(clamp), .i_sync_rate_tick(tick), .i_async_rate_tick(tick), .i_gpio10_in(p10),
    .o_gpio_out(gout), .o_gpio_oe(goe), .o_irq(irq), .o_switch_one_closed(sw1),
    .o_switch_two_closed(sw2), .o_aux_pdm_ext_clk(pdmx), .o_sync_divided_clock_out(sclk),
    .o_async_divided_clock_out(aclk));
  gcso_pin_partner pp (.i_core_clk(i_core_clk), .i_run(prun), .o_pin(p10));

  function automatic logic sw_exp(gcso_sw_mode_t m, logic c);
    return m[1] ? (m[0] ^ c) : m[0];
  endfunction
  task automatic note(int id, logic [31:0] e);
    q.push_back('{id, e, meas});
    -> probe;
  endtask
  // One AHB single transfer; request held until hready is seen at an edge
  task automatic bus(logic w, logic [9:0] a, logic [31:0] wd);
    @(posedge i_core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0_0000, a, 2'h0};
    do @(posedge i_core_clk); while (hro !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge i_core_clk); while (hro !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wr(logic [9:0] a, logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(logic [9:0] a, logic [31:0] e);
    bus(1'b0, a, '0);
    note(0, e);
    note(5, 32'h0000_0001);
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // Full period of a pin, measured rise to rise
  task automatic per(int b);
    while (gout[b] !== 1'b0) @(posedge i_core_clk);
    while (gout[b] !== 1'b1) @(posedge i_core_clk);
    meas = 0;
    while (gout[b] !== 1'b0) begin @(posedge i_core_clk); meas++; end
    while (gout[b] !== 1'b1) begin @(posedge i_core_clk); meas++; end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Every pending note, oldest first, is compared against the outputs as they stand at this edge
  always begin
    @(probe);
    while (q.size() > 0) begin
      nt = q.pop_front();
      case (nt.id)
        0: `CHK("hrdata", nt.e, rdat)
        1: `CHK("gpio_out", nt.e[15:0], gout)
        2: `CHK("gpio_oe", nt.e[15:0], goe)
        3: `CHK("pdm_irq_sw", nt.e[3:0], {pdmx, irq, sw2, sw1})
        5: `CHK("hresp_ready", nt.e[1:0], {hresp, hro})
        default: `CHK("measure", nt.e, nt.g)
      endcase
    end
  end

  // Longest run is the divider sweep, well under this span
  initial begin
    wt(40000);
    error_cnt++;
    close_out();
  end

  initial begin
    wt(6);
    i_sys_rst <= 1'b0;
    rd(10'h149, 0);
    rd(10'h14A, 0);
    rd(10'h2C8, 0);
    rd(10'h123, 0);
    // Even divider and a defined source, since the write also enables the output
    wr(10'h149, 32'hFFFF_FFF3);
    rd(10'h149, 32'h0000_80F3);
    // Random fields with the enable cleared, so odd or reserved codes are legal
    meas = $random(seed) & 32'hFFFF_7FFF;
    wr(10'h14A, meas);
    rd(10'h14A, meas & 32'h0000_80FF);
    // Every switch mode against both clamp levels
    for (int i = 0; i < 8; i++) begin
      clamp <= i[2];
      wr(10'h2C8, {28'h0, ~i[1:0], i[1:0]});
      wt(2);
      note(3, {2'h0, sw_exp(gcso_sw_mode_t'(~i[1:0]), i[2]), sw_exp(gcso_sw_mode_t'(i[1:0]), i[2])});
    end
    // Each lock, PWM, S/PDIF and logger function on GPIO5, raised then dropped
    for (int i = 0; i < 8; i++) begin
      wr(10'h314, {22'h0, fn[i]});
      src[i] <= 1'b1;
      wt(6);
      note(1, 16'h0010);
      note(2, 16'h0010);
      src[i] <= 1'b0;
      wt(6);
      note(1, 0);
    end
    rd(10'h300, 32'h0000_002F);
    note(3, 4'h4);
    wr(10'h300, 32'h0000_0001);
    rd(10'h300, 32'h0000_002E);
    wr(10'h300, 32'h0000_03FF);
    wt(3);
    note(3, 4'h0);
    // Timer pulse then each alarm with a three-cycle length
    wr(10'h301, 32'h0000_0003);
    for (int i = 0; i < 5; i++) begin
      wr(10'h315, i ? 32'h0000_022F + i : 32'h0000_0140);
      if (i) alm[i-1] <= 1'b1;
      else tfin <= 1'b1;
      @(posedge i_core_clk);
      alm  <= 4'h0;
      tfin <= 1'b0;
      meas = 0;
      repeat (12) begin @(posedge i_core_clk); meas += gout[5]; end
      note(4, i ? 3 : 1);
    end
    rd(10'h300, 32'h0000_03D0);
    // A timer event in the clear's own data edge must survive it
    fork
      wr(10'h300, 32'h0000_03FF);
      begin
        wt(2);
        tfin <= 1'b1;
        @(posedge i_core_clk);
        tfin <= 1'b0;
      end
    join
    rd(10'h300, 32'h0000_0010);
    // Raw lock status follows the synchronised flags
    src[3:0] <= 4'hF;
    wt(3);
    rd(10'h302, 32'h0000_000F);
    src[3:0] <= 4'h0;
    wt(3);
    wr(10'h300, 32'h0000_03FF);
    // Divided clocks on GPIO1 and GPIO2, random even ratio, each of source codes 0 to 3
    wr(10'h310, 32'h0000_0040);
    wr(10'h311, 32'h0000_0041);
    for (int i = 0; i < 8; i++) begin
      d = 2 * ($unsigned($random(seed)) % 15) + 2;
      for (int k = 0; k < 2; k++) begin
        wr(10'(10'h149 + k), 32'h0);
        wr(10'(10'h149 + k), {16'h0, 1'b1, 7'h0, 5'(d), 3'(i % 4)});
      end
      per(0);
      note(4, d << (i % 4));
      per(1);
      note(4, d << (i % 4));
    end
    wr(10'h149, 32'h0);
    wr(10'h14A, 32'h0);
    wt(3);
    meas = 0;
    repeat (20) begin @(posedge i_core_clk); meas += gout[0] + gout[1] + sclk + aclk; end
    note(4, 0);
    // Aux PDM master on GPIO3/4, then slave with clock in on GPIO10
    wr(10'h301, 32'h0000_0103);
    wr(10'h312, 32'h0000_0280);
    wr(10'h313, 32'h0000_0281);
    src[9:8] <= 2'h3;
    wt(3);
    note(1, 16'h000C);
    wr(10'h301, 32'h0000_0003);
    wr(10'h319, 32'h0000_0280);
    wr(10'h318, 32'h0000_0281);
    prun <= 1'b1;
    wt(6);
    meas = {goe[9], goe[8], gout[8]};
    note(4, 3'b011);
    meas = 0;
    repeat (36) begin @(posedge i_core_clk); meas += (pdmx != last); last = pdmx; end
    note(4, 12);
    prun <= 1'b0;
    wt(2);
    close_out();
  end
endmodule
